// >>> rtl/ewt_timer.sv
// eight-bit wrap timer with avalon-mm register slave
// assumes fixed clock and timer pin are asynchronous to I_CORE_CLK
`timescale 1ns/10ps
module ewt_timer (
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RESET_N,
  // avalon-mm slave
  input  wire logic [3:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]  I_AVS_BYTEENABLE,
  output logic      [31:0] O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  // count sources
  input  wire logic        I_FIXED_FREQ_CLOCK,
  input  wire logic        I_EXT_TIMER_CLOCK_PIN,
  // interrupt request
  output logic             O_OVERFLOW_IRQ
);
  import ewt_pkg::*;

  logic [7:0] count_register;
  logic [7:0] wrap_compare_value;
  logic       overflow_flag;
  logic       overflow_irq_enable;
  logic       counter_halt;
  ewt_src_e   clock_source_select;
  logic [3:0] prescale_select;
  logic [7:0] prescale_count;
  logic       clear_armed;
  logic       answered;
  logic [2:0] fix_sync;
  logic [2:0] pin_sync;
  logic [31:0] rdata;

  // one-wait-state slave: a request is answered the cycle after it appears
  wire access     = I_AVS_READ | I_AVS_WRITE;
  wire take       = access & answered;
  wire lane0      = I_AVS_BYTEENABLE[0];
  wire wr_sc      = take & I_AVS_WRITE & lane0 & (I_AVS_ADDRESS == EWT_ADDR_SC);
  wire wr_clk     = take & I_AVS_WRITE & lane0 & (I_AVS_ADDRESS == EWT_ADDR_CLK);
  wire wr_cmp     = take & I_AVS_WRITE & lane0 & (I_AVS_ADDRESS == EWT_ADDR_CMP);
  wire rd_sc      = take & I_AVS_READ & (I_AVS_ADDRESS == EWT_ADDR_SC);
  wire wd_clr     = I_AVS_WRITEDATA[EWT_BIT_CLR];
  wire wd_ovf     = I_AVS_WRITEDATA[EWT_BIT_OVF];

  assign O_AVS_WAITREQUEST = access & ~answered;

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      answered <= 1'b0;
    end else begin
      answered <= access & ~answered;
    end
  end

  // three stages: first two synchronise, third is the edge history
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      fix_sync <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      fix_sync <= {fix_sync[1:0], I_FIXED_FREQ_CLOCK};
      pin_sync <= {pin_sync[1:0], I_EXT_TIMER_CLOCK_PIN};
    end
  end

  // fixed clock counts on its rising edge; pin edge chosen by source
  wire fix_rise  = fix_sync[1] & ~fix_sync[2];
  wire pin_rise  = pin_sync[1] & ~pin_sync[2];
  wire pin_fall  = ~pin_sync[1] & pin_sync[2];

  logic src_tick;
  always_comb begin
    unique case (clock_source_select)
      EWT_SRC_BUS:  src_tick = 1'b1;
      EWT_SRC_FIX:  src_tick = fix_rise;
      EWT_SRC_FALL: src_tick = pin_fall;
      EWT_SRC_RISE: src_tick = pin_rise;
    endcase
  end

  // prescaler free-runs on source ticks; tap selects the ratio
  function automatic logic [3:0] ewt_ps_clip(input logic [3:0] ps);
    ewt_ps_clip = (ps > EWT_PS_MAX) ? EWT_PS_MAX : ps;
  endfunction : ewt_ps_clip

  wire [3:0] ps_eff    = ewt_ps_clip(prescale_select);
  wire [8:0] ps_mask   = 9'((9'h001 << ps_eff) - 9'h001);
  wire       running   = ~counter_halt;
  wire       ps_full   = ((prescale_count & ps_mask[7:0]) == ps_mask[7:0]);
  wire       inc       = running & src_tick & ps_full;
  // zero compare never matches before 8'hFF, so plain wrap gives free run
  wire       at_wrap   = (wrap_compare_value == EWT_CMP_RESET) ?
                         (count_register == 8'hFF) :
                         (count_register == wrap_compare_value);
  wire       overflow  = inc & at_wrap;
  wire       cnt_clear = wr_cmp | (wr_sc & wd_clr);

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      prescale_count <= 8'h00;
    end else if (cnt_clear) begin
      prescale_count <= 8'h00;
    end else if (running & src_tick) begin
      prescale_count <= prescale_count + 8'h01;
    end
  end

  // source and prescale writes leave the count alone
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      count_register <= EWT_CNT_RESET;
    end else if (cnt_clear) begin
      count_register <= EWT_CNT_RESET;
    end else if (overflow) begin
      count_register <= EWT_CNT_RESET;
    end else if (inc) begin
      count_register <= count_register + 8'h01;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wrap_compare_value  <= EWT_CMP_RESET;
      clock_source_select <= EWT_SRC_BUS;
      prescale_select     <= EWT_PS_RESET;
      counter_halt        <= EWT_HALT_RESET;
      overflow_irq_enable <= 1'b0;
    end else begin
      if (wr_cmp) begin
        wrap_compare_value <= I_AVS_WRITEDATA[7:0];
      end
      if (wr_clk) begin
        clock_source_select <= ewt_src_e'(I_AVS_WRITEDATA[EWT_SRC_HI:EWT_SRC_LO]);
        prescale_select     <= I_AVS_WRITEDATA[EWT_PS_HI:EWT_PS_LO];
      end
      if (wr_sc) begin
        counter_halt        <= I_AVS_WRITEDATA[EWT_BIT_HALT];
        overflow_irq_enable <= I_AVS_WRITEDATA[EWT_BIT_IRQ_EN];
      end
    end
  end

  // a new overflow disarms the pending clear and wins over any clear
  wire flag_clear = cnt_clear | (wr_sc & ~wd_ovf & clear_armed);

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      overflow_flag <= 1'b0;
      clear_armed   <= 1'b0;
    end else begin
      if (overflow) begin
        overflow_flag <= 1'b1;
      end else if (flag_clear) begin
        overflow_flag <= 1'b0;
      end
      if (overflow | flag_clear) begin
        clear_armed <= 1'b0;
      end else if (rd_sc & overflow_flag) begin
        clear_armed <= 1'b1;
      end
    end
  end

  assign O_OVERFLOW_IRQ = overflow_flag & overflow_irq_enable;

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (I_AVS_ADDRESS)
      EWT_ADDR_SC: begin
        rdata[EWT_BIT_OVF]    = overflow_flag;
        rdata[EWT_BIT_IRQ_EN] = overflow_irq_enable;
        rdata[EWT_BIT_HALT]   = counter_halt; // clear bit reads zero
      end
      EWT_ADDR_CLK: rdata[EWT_SRC_HI:EWT_PS_LO] = {clock_source_select, prescale_select};
      EWT_ADDR_CNT: rdata[7:0] = count_register;
      EWT_ADDR_CMP: rdata[7:0] = wrap_compare_value;
      default:      rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_AVS_READDATA <= 32'h0000_0000;
    end else if (I_AVS_READ & ~answered) begin
      O_AVS_READDATA <= rdata;
    end
  end
endmodule : ewt_timer

// >>> rtl/ewt_pkg.sv
// constants, register map and field layout of the eight-bit wrap timer
// assumes a 32-bit avalon-mm slave with word-aligned registers
package ewt_pkg;
  localparam logic [3:0] EWT_ADDR_SC      = 4'h0;
  localparam logic [3:0] EWT_ADDR_CLK     = 4'h4;
  localparam logic [3:0] EWT_ADDR_CNT     = 4'h8;
  localparam logic [3:0] EWT_ADDR_CMP     = 4'hC;
  localparam int         EWT_BIT_OVF      = 7;
  localparam int         EWT_BIT_IRQ_EN   = 6;
  localparam int         EWT_BIT_CLR      = 5;
  localparam int         EWT_BIT_HALT     = 4;
  localparam int         EWT_SRC_HI       = 5;
  localparam int         EWT_SRC_LO       = 4;
  localparam int         EWT_PS_HI        = 3;
  localparam int         EWT_PS_LO        = 0;
  localparam logic [3:0] EWT_PS_MAX       = 4'h8;
  localparam logic [7:0] EWT_CNT_RESET    = 8'h00;
  localparam logic [7:0] EWT_CMP_RESET    = 8'h00;
  localparam logic [3:0] EWT_PS_RESET     = 4'h0;
  localparam logic       EWT_HALT_RESET   = 1'b1;
  typedef enum logic [1:0] {
    EWT_SRC_BUS  = 2'b00,
    EWT_SRC_FIX  = 2'b01,
    EWT_SRC_FALL = 2'b10,
    EWT_SRC_RISE = 2'b11
  } ewt_src_e;
endpackage : ewt_pkg

// >>> tb/ewt_timer_chk.sv
// port checker for the wrap timer bus and irq
// assumes one core clock and async low reset
`timescale 1ns/10ps
module ewt_chk import ewt_pkg::*; (
  input wire logic        I_CORE_CLK, I_RESET_N, I_AVS_READ, I_AVS_WRITE,
  input wire logic [3:0]  I_AVS_ADDRESS, I_AVS_BYTEENABLE,
  input wire logic [31:0] I_AVS_WRITEDATA, O_AVS_READDATA,
  input wire logic        O_AVS_WAITREQUEST, I_FIXED_FREQ_CLOCK,
  input wire logic        I_EXT_TIMER_CLOCK_PIN, O_OVERFLOW_IRQ
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);
  wire       req = I_AVS_READ | I_AVS_WRITE;
  wire       rda = I_AVS_READ & !O_AVS_WAITREQUEST;
  wire [3:0] a   = I_AVS_ADDRESS;
  wire       wsc = I_AVS_WRITE & !O_AVS_WAITREQUEST & I_AVS_BYTEENABLE[0] & (a == EWT_ADDR_SC);
  a_wait_first: assert property ($rose(req) |-> O_AVS_WAITREQUEST)
    else $error("no wait state on new request");
  a_wait_one: assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("wait state too long");
  a_rdata_hold: assert property ($changed(O_AVS_READDATA) |-> $past(I_AVS_READ))
    else $error("read data moved without a read");
  a_upper_zero: assert property (rda |-> O_AVS_READDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (rda && a[1:0] != 2'h0 |-> O_AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_clr_reads0: assert property (rda && a == EWT_ADDR_SC |-> !O_AVS_READDATA[EWT_BIT_CLR])
    else $error("counter clear bit read as one");
  a_clk_spare: assert property (rda && a == EWT_ADDR_CLK |-> O_AVS_READDATA[7:6] == 2'h0)
    else $error("clock config spare bits set");
  a_irq_off: assert property (wsc && !I_AVS_WRITEDATA[EWT_BIT_IRQ_EN] |=> !O_OVERFLOW_IRQ)
    else $error("irq stays with enable cleared");
  c_cnt_read: cover property (rda && a == EWT_ADDR_CNT);
  c_irq_rise: cover property ($rose(O_OVERFLOW_IRQ));
  c_sc_write: cover property (wsc);
endmodule : ewt_chk
bind ewt_timer ewt_chk chk_u (.*);

// >>> tb/ewt_timer_test.sv
// self-checking bench: registers, flag clearing, prescaler and count sources
// assumes a one-wait-state slave on a 50 MHz clock
`timescale 1ns/10ps
module ewt_timer_test;
  import ewt_pkg::*;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, fix = 0, pin = 0, wrq, irq;
  logic [3:0]  adr = '0, be = 4'hF;
  logic [31:0] wd = '0, rdat, q;
  int          err_total = 0, check_count = 0;
  ewt_timer dut_u (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wrq), .I_FIXED_FREQ_CLOCK(fix),
    .I_EXT_TIMER_CLOCK_PIN(pin), .O_OVERFLOW_IRQ(irq));
  initial forever #10 clk = ~clk;
  // request held until the rising edge that sees waitrequest low; watchdog ends a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wrq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] e);
    check_count++;
    if (q !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, q);
    end
  endtask : chk
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e);
  endtask : rdc
  task automatic chk_irq(input logic e);
    @(negedge clk);
    q = {31'h0, irq};
    chk("irq", {31'h0, e});
  endtask : chk_irq
  task automatic t_regs;
    rdc(EWT_ADDR_SC, 32'h10, "sc reset");
    rdc(EWT_ADDR_CLK, 32'h0, "clk reset");
    rdc(EWT_ADDR_CMP, 32'h0, "cmp reset");
    bus(1'b1, EWT_ADDR_CMP, 32'h55);
    be <= 4'h0;
    bus(1'b1, EWT_ADDR_CMP, 32'h99);
    be <= 4'hF;
    rdc(EWT_ADDR_CMP, 32'h55, "cmp rw");
    bus(1'b1, 4'h2, 32'hFF);
    rdc(4'h2, 32'h0, "unmapped");
    bus(1'b1, EWT_ADDR_CNT, 32'h12);
    rdc(EWT_ADDR_CNT, 32'h0, "cnt ro");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_flag;
    bus(1'b1, EWT_ADDR_CMP, 32'h03);
    bus(1'b1, EWT_ADDR_SC, 32'h00);
    repeat (8) @(posedge clk);
    rdc(EWT_ADDR_SC, 32'h80, "flag run");
    repeat (8) @(posedge clk);
    bus(1'b1, EWT_ADDR_SC, 32'h10);
    rdc(EWT_ADDR_SC, 32'h90, "flag race");
    bus(1'b1, EWT_ADDR_SC, 32'h10);
    rdc(EWT_ADDR_SC, 32'h10, "flag clear");
    bus(1'b1, EWT_ADDR_SC, 32'h40);
    repeat (8) @(posedge clk);
    chk_irq(1'b1);
    bus(1'b1, EWT_ADDR_SC, 32'h10);
    chk_irq(1'b0);
    bus(1'b1, EWT_ADDR_CMP, 32'h07);
    rdc(EWT_ADDR_SC, 32'h10, "cmp flag");
    rdc(EWT_ADDR_CNT, 32'h0, "cmp count");
    $display("t_flag done");
  endtask : t_flag
  task automatic t_ps;
    int w;
    for (int p = 0; p < 16; p++) begin
      w = 1 << ((p > 8) ? 8 : p);
      // halt first so a late overflow cannot land on the clearing write
      bus(1'b1, EWT_ADDR_SC, 32'h30);
      bus(1'b1, EWT_ADDR_CLK, 32'(p));
      bus(1'b1, EWT_ADDR_SC, 32'h20);
      repeat (6 * w - 2) @(posedge clk);
      rdc(EWT_ADDR_SC, 32'h00, "ps early");
      repeat (2 * w + 2) @(posedge clk);
      rdc(EWT_ADDR_SC, 32'h80, "ps wrap");
      rdc(EWT_ADDR_CLK, 32'(p), "ps kept");
    end
    $display("t_ps done");
  endtask : t_ps
  task automatic t_src;
    bus(1'b1, EWT_ADDR_CMP, 32'h00);
    for (int s = 1; s < 4; s++) begin
      bus(1'b1, EWT_ADDR_CLK, 32'(s << 4));
      bus(1'b1, EWT_ADDR_SC, 32'h20);
      for (int i = 0; i < 5; i++) begin
        fix <= (i < 3);
        pin <= 1'b1;
        repeat (4) @(posedge clk);
        fix <= 1'b0;
        pin <= (i == 4);
        repeat (4) @(posedge clk);
      end
      bus(1'b1, EWT_ADDR_SC, 32'h10);
      rdc(EWT_ADDR_CNT, 32'(s + 2), "src count");
      pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    bus(1'b1, EWT_ADDR_CLK, 32'h0);
    bus(1'b1, EWT_ADDR_SC, 32'h20);
    repeat (245) @(posedge clk);
    rdc(EWT_ADDR_SC, 32'h00, "free early");
    repeat (10) @(posedge clk);
    rdc(EWT_ADDR_SC, 32'h80, "free wrap");
    $display("t_src done");
  endtask : t_src
  // reset in mid-run, with the counter running and the flag set
  task automatic t_rst;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(EWT_ADDR_SC, 32'h10, "rst sc");
    rdc(EWT_ADDR_CNT, 32'h0, "rst cnt");
    rdc(EWT_ADDR_CMP, 32'h0, "rst cmp");
    rdc(EWT_ADDR_CLK, 32'h0, "rst clk");
    $display("t_rst done");
  endtask : t_rst
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_flag;
    t_ps;
    t_src;
    t_rst;
    end_sim;
  end
  // sized well past the longest prescaler pass
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    end_sim;
  end
endmodule : ewt_timer_test
